// *** design/serial_eeprom_spi_slave_port.sv ***
// Slave serial port of a small non-volatile memory, sampled on ref_clk
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_spi_slave_port #(
  parameter int BYTE_WRITE_CYCLES = spi_port_pkg::BYTE_WRITE_CYCLES,
  parameter int PAGE_WRITE_CYCLES = spi_port_pkg::PAGE_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // Serial pins from the master
  input  wire spi_port_pkg::spi_pins_t pins,
  // Serial output pin
  output logic                         serial_out_line,
  output logic                         serial_out_oe_n,
  // Read data stream from the memory core
  input  wire logic [7:0]              tx_data,
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  // Received bytes towards the memory core
  output logic [7:0]                   rx_byte,
  output logic                         rx_valid,
  // Status
  output logic                         busy_flag,
  output logic                         standby,
  output logic                         asleep
);

  spi_port_pkg::spi_pins_t sync1;
  spi_port_pkg::spi_pins_t sync2;
  spi_port_pkg::phase_t    phase;
  logic                        sck_d;
  logic                        sel_q;
  logic                        selected;
  logic                        active;
  logic                        sck_rise;
  logic                        sck_fall;
  logic                        sel_edge;
  logic                        desel_edge;
  logic                        byte_done;
  logic [7:0]                  new_byte;
  logic [2:0]                  bit_cnt;
  logic [6:0]                  rx_shift;
  logic [7:0]                  command;
  logic [5:0]                  byte_cnt;
  logic [7:0]                  tx_shift;
  logic [7:0]                  load_byte;
  logic [7:0]                  status_byte;
  logic                        driving;
  logic                        out_slot;
  logic                        fifo_pop;
  logic [7:0]                  fifo_data;
  logic                        fifo_valid;
  logic                        deep;
  logic                        write_start;
  logic                        frame_whole;
  logic [spi_port_pkg::TIMER_W-1:0] timer;

  // Commands that carry an address
  function automatic logic has_address(input logic [7:0] cmd);
    return cmd == spi_port_pkg::WRITE_COMMAND ||
           cmd == spi_port_pkg::READ_COMMAND ||
           cmd == spi_port_pkg::FAST_READ_COMMAND ||
           cmd == spi_port_pkg::PAGE_ERASE_COMMAND;
  endfunction : has_address

  // Commands that answer on the serial output
  function automatic logic needs_output(input logic [7:0] cmd);
    return cmd == spi_port_pkg::READ_COMMAND ||
           cmd == spi_port_pkg::FAST_READ_COMMAND ||
           cmd == spi_port_pkg::READ_STATUS_COMMAND;
  endfunction : needs_output

  // ***************************************************
  // Pin synchronisers and edge detection
  // ***************************************************
  // Two stages before any logic looks at the pins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1 <= spi_port_pkg::PINS_IDLE;
      sync2 <= spi_port_pkg::PINS_IDLE;
      sck_d <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sck_d <= sync2.sck;
      sel_q <= selected;
    end
  end

  // Clock edges count only while selected and not paused
  assign selected   = ~sync2.select_n;
  assign active     = selected & sync2.pause_n;
  assign sck_rise   = active & sync2.sck & ~sck_d;
  assign sck_fall   = active & ~sync2.sck & sck_d;
  assign sel_edge   = selected & ~sel_q;
  assign desel_edge = ~selected & sel_q;
  assign byte_done  = sck_rise & (bit_cnt == 3'h7);
  assign new_byte   = {rx_shift, sync2.serial_in_line};
  assign frame_whole = (phase == spi_port_pkg::phase_data) &&
                       (bit_cnt == 3'h0);

  // ***************************************************
  // Receive shifter
  // ***************************************************
  // Sample input on rising edges, MSB first
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !selected) begin
      bit_cnt  <= 3'h0;
      rx_shift <= 7'h00;
    end else if (sck_rise) begin
      rx_shift <= new_byte[6:0];
      bit_cnt  <= bit_cnt + 3'h1;
    end
  end

  // Hand each completed byte out
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_byte  <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= byte_done;
      if (byte_done) rx_byte <= new_byte;
    end
  end

  // ***************************************************
  // Command sequencer
  // ***************************************************
  // Walk command, address, dummy and data bytes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      phase    <= spi_port_pkg::phase_cmd;
      command  <= spi_port_pkg::NO_COMMAND;
      byte_cnt <= 6'h00;
    end else if (sel_edge) begin
      phase    <= spi_port_pkg::phase_cmd;
      command  <= spi_port_pkg::NO_COMMAND;
      byte_cnt <= 6'h00;
    end else if (byte_done) begin
      case (phase)
        spi_port_pkg::phase_cmd: begin
          // A sleeping port only listens for the resume command
          if (asleep &&
              new_byte != spi_port_pkg::RESUME_FROM_SLEEP_COMMAND) begin
            command <= spi_port_pkg::NO_COMMAND;
          end else begin
            command <= new_byte;
          end
          phase <= has_address(new_byte) ? spi_port_pkg::phase_addr
                                         : spi_port_pkg::phase_data;
        end
        spi_port_pkg::phase_addr: begin
          if (byte_cnt == 6'(spi_port_pkg::ADDR_BYTES - 1)) begin
            byte_cnt <= 6'h00;
            phase    <= (command == spi_port_pkg::FAST_READ_COMMAND) ?
                        spi_port_pkg::phase_dummy :
                        spi_port_pkg::phase_data;
          end else begin
            byte_cnt <= byte_cnt + 6'h01;
          end
        end
        spi_port_pkg::phase_dummy: begin
          phase <= spi_port_pkg::phase_data;
        end
        spi_port_pkg::phase_data: begin
          if (byte_cnt != spi_port_pkg::DATA_COUNT_MAX) begin
            byte_cnt <= byte_cnt + 6'h01;
          end
        end
        default: begin
          phase <= spi_port_pkg::phase_cmd;
        end
      endcase
    end
  end

  // ***************************************************
  // Transmit shifter and output pin
  // ***************************************************
  assign status_byte = spi_port_pkg::STATUS_RESET |
                       (8'h01 << spi_port_pkg::BUSY_BIT) &
                       {8{busy_flag}};
  // Only the data phase drives, so the mode 3 lead-in fall is ignored
  assign out_slot  = sck_fall && (phase == spi_port_pkg::phase_data) &&
                     needs_output(command);
  assign fifo_pop  = out_slot && (bit_cnt == 3'h0) &&
                     (command != spi_port_pkg::READ_STATUS_COMMAND);
  assign load_byte = (command == spi_port_pkg::READ_STATUS_COMMAND) ?
                     status_byte :
                     (fifo_valid ? fifo_data : spi_port_pkg::IDLE_FILL);

  // Shift read data on falling edges
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_shift        <= 8'h00;
      serial_out_line <= 1'b0;
    end else if (out_slot) begin
      if (bit_cnt == 3'h0) begin
        tx_shift        <= load_byte;
        serial_out_line <= load_byte[7];
      end else begin
        tx_shift        <= {tx_shift[6:0], 1'b0};
        serial_out_line <= tx_shift[6];
      end
    end
  end

  // Drive the pin only while selected, answering and not paused
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !selected) begin
      driving         <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else begin
      if (out_slot) driving <= 1'b1;
      serial_out_oe_n <= ~(driving & sync2.pause_n);
    end
  end

  // ***************************************************
  // Write cycle timer, sleep and standby
  // ***************************************************
  assign write_start = desel_edge && frame_whole && !busy_flag &&
                       (command == spi_port_pkg::WRITE_COMMAND) &&
                       (byte_cnt != 6'h00);

  // Self-timed write, busy until it ends
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timer     <= '0;
      busy_flag <= 1'b0;
    end else if (write_start) begin
      timer     <= (byte_cnt == 6'h01) ?
                   spi_port_pkg::TIMER_W'(BYTE_WRITE_CYCLES) :
                   spi_port_pkg::TIMER_W'(PAGE_WRITE_CYCLES);
      busy_flag <= 1'b1;
    end else if (timer > spi_port_pkg::TIMER_W'(1)) begin
      timer <= timer - 1'b1;
    end else begin
      timer     <= '0;
      busy_flag <= 1'b0;
    end
  end

  // Sleep modes entered on deselect, left by command or select
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      asleep <= 1'b0;
      deep   <= 1'b0;
    end else if (sel_edge && deep) begin
      asleep <= 1'b0;
      deep   <= 1'b0;
    end else if (desel_edge && frame_whole) begin
      case (command)
        spi_port_pkg::SLEEP_COMMAND:             asleep <= 1'b1;
        spi_port_pkg::ULTRA_DEEP_SLEEP_COMMAND: begin
          asleep <= 1'b1;
          deep   <= 1'b1;
        end
        spi_port_pkg::RESUME_FROM_SLEEP_COMMAND: asleep <= 1'b0;
        default:                                 asleep <= asleep;
      endcase
    end
  end

  // Standby follows the synchronised select
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      standby <= 1'b1;
    end else begin
      standby <= ~selected;
    end
  end

  // ***************************************************
  // Read data buffer
  // ***************************************************
  byte_fifo #(
    .WIDTH (spi_port_pkg::BYTE_W),
    .DEPTH (spi_port_pkg::FIFO_DEPTH)
  ) read_buffer (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  active_only_a: assert property (rx_valid |-> $past(selected))
    else $error("byte taken while deselected");
  idle_ignore_a: assert property (!selected |=> !rx_valid)
    else $error("input accepted while deselected");
  deselect_quiet_a: assert property (!selected |=> serial_out_oe_n)
    else $error("output driven while deselected");
  rise_sample_a: assert property (byte_done |=> rx_valid &&
                   rx_byte == $past(new_byte))
    else $error("received byte wrong");
  fall_shift_a: assert property ($changed(serial_out_line) |->
                  $past(sck_fall))
    else $error("output changed off a falling edge");
  pause_hold_a: assert property (selected && !sync2.pause_n |=>
                  $stable(bit_cnt) && $stable(phase))
    else $error("sequence moved during pause");
  standby_entry_a: assert property (desel_edge |=> standby)
    else $error("standby late");
  msb_first_a: assert property (out_slot && bit_cnt == 3'h0 |=>
                 serial_out_line == $past(load_byte[7]))
    else $error("first output bit not MSB");
  cmd_silent_a: assert property (phase == spi_port_pkg::phase_cmd
                  |=> serial_out_oe_n)
    else $error("output driven in command phase");
  write_busy_a: assert property (write_start |=> busy_flag[*8])
    else $error("write cycle ended too soon");

  status_read_c: cover property (out_slot &&
                   command == spi_port_pkg::READ_STATUS_COMMAND);
  write_cycle_c: cover property (write_start);
  paused_read_c: cover property (driving && !sync2.pause_n);

endmodule : serial_eeprom_spi_slave_port
`default_nettype wire

// *** design/spi_port_pkg.sv ***
// Constants, types and command codes of the serial memory slave port
package spi_port_pkg;

  // ***************************************************
  // Clock and timing
  // ***************************************************
  localparam int CLK_PERIOD_NS  = 4;
  localparam int BYTE_WRITE_NS  = 25000;
  localparam int PAGE_WRITE_NS  = 1000000;
  localparam int STANDBY_MAX_NS = 8000;
  localparam int BYTE_WRITE_CYCLES = BYTE_WRITE_NS / CLK_PERIOD_NS;
  localparam int PAGE_WRITE_CYCLES = PAGE_WRITE_NS / CLK_PERIOD_NS;
  localparam int STANDBY_CYCLES    = STANDBY_MAX_NS / CLK_PERIOD_NS;
  localparam int TIMER_W           = 18;

  // ***************************************************
  // Framing and buffering
  // ***************************************************
  localparam int BYTE_W      = 8;
  localparam int FIFO_DEPTH  = 16;
  localparam int ADDR_BYTES  = 2;
  localparam int BUSY_BIT    = 0;
  localparam logic [5:0] DATA_COUNT_MAX = 6'h3f;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam logic [7:0] IDLE_FILL      = 8'h00;

  // ***************************************************
  // Command codes
  // ***************************************************
  localparam logic [7:0] WRITE_COMMAND             = 8'h02;
  localparam logic [7:0] READ_COMMAND              = 8'h03;
  localparam logic [7:0] READ_STATUS_COMMAND       = 8'h05;
  localparam logic [7:0] FAST_READ_COMMAND         = 8'h0b;
  localparam logic [7:0] PAGE_ERASE_COMMAND        = 8'h42;
  localparam logic [7:0] ULTRA_DEEP_SLEEP_COMMAND  = 8'h79;
  localparam logic [7:0] SLEEP_COMMAND             = 8'hb9;
  localparam logic [7:0] RESUME_FROM_SLEEP_COMMAND = 8'hab;
  localparam logic [7:0] NO_COMMAND                = 8'h00;

  // ***************************************************
  // Types
  // ***************************************************
  typedef struct packed {
    logic select_n;
    logic sck;
    logic serial_in_line;
    logic pause_n;
  } spi_pins_t;

  localparam spi_pins_t PINS_IDLE = '{select_n: 1'b1, sck: 1'b0,
                                      serial_in_line: 1'b0, pause_n: 1'b1};

  typedef enum {phase_cmd, phase_addr, phase_dummy, phase_data} phase_t;

endpackage : spi_port_pkg

// *** design/byte_fifo.sv ***
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Filling side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Draining side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // Handshakes on both sides
  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  // ***************************************************
  // Storage and pointers
  // ***************************************************
  // Write the storage word
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Advance the pointers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // ***************************************************
  // Fill level and flags
  // ***************************************************
  // Next fill level
  always_comb begin
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Registered full and empty flags
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count     <= next_count;
      in_ready  <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

endmodule : byte_fifo
`default_nettype wire

// *** testbench/spi_master_model.sv ***
// Serial master model that drives the memory port's pins
`timescale 1ns/100ps
`default_nettype none
module spi_master_model #(
  // Half link clock in ref_clk cycles; raise it for slower reads
  parameter int HALF_CYCLES = 10
) (
  // Clock
  input  wire logic                   ref_clk,
  // Pins towards the port
  output var spi_port_pkg::spi_pins_t pins,
  // Serial output pin of the port
  input  wire logic                   serial_out_line,
  input  wire logic                   serial_out_oe_n
);
  logic last_out;
  logic sdo_wire;
  logic mode3;
  int   pause_bit;

  // Idle pins at time zero
  initial begin
    pins      = spi_port_pkg::PINS_IDLE;
    last_out  = 1'b0;
    mode3     = 1'b0;
    pause_bit = -1;
  end

  // Released pin shows the inverse of its last driven level
  always @(posedge ref_clk) begin
    if (serial_out_oe_n === 1'b0) last_out <= serial_out_line;
  end
  assign sdo_wire = (serial_out_oe_n === 1'b0) ? serial_out_line : ~last_out;

  task automatic half_bit();
    repeat (HALF_CYCLES) @(negedge ref_clk);
  endtask : half_bit

  // Park the clock at the mode's idle level, then select
  task automatic start(input logic m3);
    @(negedge ref_clk);
    mode3    = m3;
    pins.sck = m3;
    half_bit();
    pins.select_n = 1'b0;
    half_bit();
  endtask : start

  // One byte, MSB first; input launched low, output taken at the rise
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      pins.sck            = 1'b0;
      pins.serial_in_line = tx[i];
      if (i == pause_bit) begin
        // Let the fall be seen before pausing, clock low as required
        half_bit();
        pins.pause_n = 1'b0;
        repeat (2) begin
          half_bit();
          pins.sck            = 1'b1;
          pins.serial_in_line = ~tx[i];
          half_bit();
          pins.sck            = 1'b0;
          pins.serial_in_line = tx[i];
        end
        half_bit();
        pins.pause_n = 1'b1;
      end
      half_bit();
      pins.sck = 1'b1;
      rx[i]    = sdo_wire;
      half_bit();
    end
  endtask : xbyte

  // Deselect and keep select high well past the minimum gap
  task automatic stop();
    if (!mode3) pins.sck = 1'b0;
    half_bit();
    pins.select_n       = 1'b1;
    pins.serial_in_line = ~pins.serial_in_line;
    repeat (8) @(negedge ref_clk);
  endtask : stop
endmodule : spi_master_model
`default_nettype wire

// *** testbench/test_serial_eeprom_spi_slave_port.sv ***
// Self-checking testbench of the serial memory slave port
`timescale 1ns/100ps
`default_nettype none
module test_serial_eeprom_spi_slave_port;
  localparam int BW    = 600;
  localparam int PW    = 1500;
  localparam int LIMIT = 60000;

  logic                    ref_clk = 1'b0;
  logic                    rst_n   = 1'b0;
  spi_port_pkg::spi_pins_t pins;
  logic                    serial_out_line;
  logic                    serial_out_oe_n;
  logic [7:0]              tx_data = 8'h00;
  logic                    tx_valid = 1'b0;
  logic                    tx_ready;
  logic [7:0]              rx_byte;
  logic                    rx_valid;
  logic                    busy_flag;
  logic                    standby;
  logic                    asleep;
  int                      n_errors = 0;
  int                      comparisons = 0;
  int                      n_rx = 0;
  int                      cycles = 0;
  int                      run = 0;
  int                      last_run = 0;
  logic [7:0]              rx_log [64];
  logic [7:0]              tx_buf [20];
  logic [7:0]              rx_buf [20];

  always #2 ref_clk = ~ref_clk;

  serial_eeprom_spi_slave_port #(
    .BYTE_WRITE_CYCLES(BW),
    .PAGE_WRITE_CYCLES(PW)
  ) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .pins(pins),
    .serial_out_line(serial_out_line), .serial_out_oe_n(serial_out_oe_n),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .busy_flag(busy_flag),
    .standby(standby), .asleep(asleep)
  );

  spi_master_model m (
    .ref_clk(ref_clk), .pins(pins),
    .serial_out_line(serial_out_line), .serial_out_oe_n(serial_out_oe_n)
  );

  // Log received bytes, time busy runs, cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (rx_valid === 1'b1) begin
      rx_log[n_rx % 64] = rx_byte;
      n_rx++;
    end
    if (busy_flag === 1'b1) run++;
    else if (run != 0) begin
      last_run = run;
      run      = 0;
    end
    if (cycles == LIMIT) begin
      n_errors++;
      $display("[ERR] %0t run did not finish in time", $time);
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic frame(input logic m3, input int n);
    logic [7:0] r;
    m.start(m3);
    for (int k = 0; k < n; k++) begin
      m.xbyte(tx_buf[k], r);
      rx_buf[k] = r;
    end
    m.stop();
  endtask : frame

  // Wait for the write cycle to end, polling the busy flag
  task automatic wait_ready();
    int w;
    w = 0;
    while (busy_flag !== 1'b0 && w < PW + 200) begin
      @(negedge ref_clk);
      w++;
    end
    // One more edge so the busy monitor closes its run
    @(negedge ref_clk);
    check(busy_flag, 1'b0);
  endtask : wait_ready

  task automatic t_reset();
    check({standby, serial_out_oe_n}, 2'b11);
    check({busy_flag, asleep, tx_ready}, 3'b001);
    $display("done: reset values");
  endtask : t_reset

  task automatic t_ignored();
    int n0;
    logic [7:0] r;
    n0 = n_rx;
    m.xbyte(8'h05, r);
    m.stop();
    check(n_rx - n0, 0);
    check(serial_out_oe_n, 1'b1);
    $display("done: deselected clocking ignored");
  endtask : t_ignored

  task automatic t_status();
    int n0;
    n0 = n_rx;
    tx_buf[0] = 8'h05;
    tx_buf[1] = 8'hff;
    tx_buf[2] = 8'h5a;
    frame(1'b0, 3);
    check(n_rx - n0, 3);
    check({rx_log[n0 % 64], rx_log[(n0 + 2) % 64]}, 16'h055a);
    check({rx_buf[1], rx_buf[2]}, 16'h0000);
    check({standby, serial_out_oe_n}, 2'b11);
    $display("done: status read idle");
  endtask : t_status

  task automatic t_byte_write();
    int n0;
    n0 = n_rx;
    tx_buf[0] = 8'h02;
    tx_buf[1] = 8'h00;
    tx_buf[2] = 8'h10;
    tx_buf[3] = 8'h5a;
    frame(1'b0, 4);
    tx_buf[0] = 8'h05;
    tx_buf[1] = 8'h00;
    frame(1'b0, 2);
    check(rx_buf[1], 8'h01);
    check(rx_log[(n0 + 3) % 64], 8'h5a);
    wait_ready();
    check(last_run >= BW - 1 && last_run <= BW + 2, 1'b1);
    $display("done: byte write");
  endtask : t_byte_write

  task automatic t_page_write();
    tx_buf[0] = 8'h02;
    tx_buf[1] = 8'h00;
    tx_buf[2] = 8'h20;
    tx_buf[3] = 8'h11;
    tx_buf[4] = 8'h22;
    frame(1'b1, 5);
    check(busy_flag, 1'b1);
    wait_ready();
    check(last_run >= PW - 1 && last_run <= PW + 2, 1'b1);
    $display("done: page write, clock mode 3");
  endtask : t_page_write

  task automatic t_pause();
    int n0;
    tx_buf[0] = 8'h02;
    tx_buf[1] = 8'h00;
    tx_buf[2] = 8'h30;
    tx_buf[3] = 8'h66;
    frame(1'b0, 4);
    n0 = n_rx;
    m.pause_bit = 4;
    tx_buf[0] = 8'h05;
    tx_buf[1] = 8'hc3;
    frame(1'b0, 2);
    m.pause_bit = -1;
    check(n_rx - n0, 2);
    check({rx_log[n0 % 64], rx_log[(n0 + 1) % 64]}, 16'h05c3);
    check(rx_buf[1], 8'h01);
    wait_ready();
    $display("done: pause mid byte");
  endtask : t_pause

  // Fast read: two address bytes, one dummy byte, then FIFO data
  task automatic t_fast_read();
    for (int i = 0; i < 2; i++) begin
      @(negedge ref_clk);
      tx_valid = 1'b1;
      tx_data  = 8'ha5 + 8'(i);
    end
    @(negedge ref_clk);
    tx_valid = 1'b0;
    tx_buf[0] = 8'h0b;
    tx_buf[1] = 8'h00;
    tx_buf[2] = 8'h00;
    tx_buf[3] = 8'hff;
    tx_buf[4] = 8'hff;
    tx_buf[5] = 8'hff;
    frame(1'b0, 6);
    check({rx_buf[4], rx_buf[5]}, 16'ha5a6);
    check(tx_ready, 1'b1);
    $display("done: fast read with dummy byte");
  endtask : t_fast_read

  task automatic t_fifo_read();
    int pushed;
    pushed = 0;
    for (int i = 0; i < 20; i++) begin
      @(negedge ref_clk);
      tx_valid = (tx_ready === 1'b1);
      tx_data  = 8'h30 + 8'(pushed);
      if (tx_ready === 1'b1) pushed++;
    end
    tx_valid = 1'b0;
    check(pushed, 16);
    check(tx_ready, 1'b0);
    tx_buf[0] = 8'h03;
    tx_buf[1] = 8'h00;
    tx_buf[2] = 8'h00;
    for (int k = 3; k < 20; k++) tx_buf[k] = 8'hff;
    frame(1'b1, 20);
    for (int k = 0; k < 16; k++) check(rx_buf[k + 3], 8'h30 + 8'(k));
    check({rx_buf[19], tx_ready}, 9'h001);
    $display("done: fifo fill and read");
  endtask : t_fifo_read

  task automatic t_sleep();
    tx_buf[0] = 8'hb9;
    frame(1'b0, 1);
    check(asleep, 1'b1);
    tx_buf[0] = 8'h02;
    tx_buf[1] = 8'h00;
    tx_buf[2] = 8'h00;
    tx_buf[3] = 8'h77;
    frame(1'b0, 4);
    check(busy_flag, 1'b0);
    tx_buf[0] = 8'hab;
    frame(1'b0, 1);
    check(asleep, 1'b0);
    repeat (12500) @(negedge ref_clk);
    tx_buf[0] = 8'h79;
    frame(1'b0, 1);
    check(asleep, 1'b1);
    m.start(1'b0);
    m.stop();
    check(asleep, 1'b0);
    repeat (17500) @(negedge ref_clk);
    $display("done: sleep and wake");
  endtask : t_sleep

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // Reset, then the scenarios in turn
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    t_reset();
    t_ignored();
    t_status();
    t_byte_write();
    t_page_write();
    t_pause();
    t_fifo_read();
    t_fast_read();
    t_sleep();
    finish_test();
  end
endmodule : test_serial_eeprom_spi_slave_port
`default_nettype wire
